// *** rtl/vpf_consts.svh ***
// Overview of operation
// [R1] Pass-any-long-type enable forwards every long data type packet to the video port.
// [R2] Type-match enable forwards packets whose data type equals the programmed match value.
// [R3] While type-match enable is set, writes to the match-value register are ignored.
// [R4] YUV pass enable with 100 MHz mode forwards data types 0x19, 0x1d, 0x1f.
// [R5] Matched-type forwarding works regardless of the 75 MHz or 100 MHz mode.
// [R6] A match occurs only if the match value is long: bit 5 or 4 set.
// [R7] Frame-valid inversion bit inverts frame-valid polarity on the video port.
// [R8] Line-valid inversion bit inverts line-valid polarity on the video port.
`ifndef VPF_CONSTS_SVH
`define VPF_CONSTS_SVH

// Register indices; byte address is four times the index
`define VPF_IDX_FILTER_CONFIG 8'h10
`define VPF_IDX_MATCH_TYPE    8'h11
`define VPF_IDX_STATUS        8'h20

// Config field positions
`define VPF_CFG_ANY_BIT   4
`define VPF_CFG_MATCH_BIT 3
`define VPF_CFG_YUV_BIT   2
`define VPF_CFG_FV_BIT    1
`define VPF_CFG_LV_BIT    0

// Reset values
`define VPF_CFG_RESET   8'h00
`define VPF_MATCH_RESET 8'h00

// Data type codes
`define VPF_DT_YUV10_A 6'h19
`define VPF_DT_YUV10_B 6'h1d
`define VPF_DT_YUV10_C 6'h1f

`endif

// *** rtl/vpf_pkg.sv ***
package vpf_pkg;
  typedef logic [5:0] vpf_dt_t;
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_PASS,
    PS_DROP
  } vpf_pkt_state_t;
endpackage : vpf_pkg

// *** rtl/vpf_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vpf_consts.svh"
module vpf_top
  import vpf_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // AHB-Lite slave
  input  wire logic              hsel_in,
  input  wire logic [ADDR_W-1:0] haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // Video mode selection
  input  wire logic              video_mode_100mhz_in,
  input  wire logic              video_mode_75mhz_in,
  // Packet stream from the receiver
  input  wire logic              pkt_valid_in,
  input  wire logic              pkt_sop_in,
  input  wire logic              pkt_eop_in,
  input  wire vpf_dt_t           pkt_dt_in,
  input  wire logic [DATA_W-1:0] pkt_data_in,
  input  wire logic              frame_valid_in,
  input  wire logic              line_valid_in,
  // Parallel video port
  output logic                   pv_valid_out,
  output logic                   pv_sop_out,
  output logic                   pv_eop_out,
  output vpf_dt_t                pv_dt_out,
  output logic      [DATA_W-1:0] pv_data_out,
  output logic                   frame_valid_out,
  output logic                   line_valid_out
);

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: address phase captured, applied in data phase

  logic [7:0]        cfg_q,      cfg_d;
  logic [7:0]        match_q,    match_d;
  logic              wr_pend_q,  wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q,  wr_addr_d;
  logic [31:0]       rdata_q,    rdata_d;
  logic [15:0]       fwd_cnt_q,  fwd_cnt_d;
  vpf_pkt_state_t    pkt_st_q,   pkt_st_d;
  logic              addr_phase;

  always_comb begin
    addr_phase = hsel_in && hready_in && htrans_in[1];
    cfg_d      = cfg_q;
    match_d    = match_q;
    wr_pend_d  = addr_phase && hwrite_in;
    wr_addr_d  = addr_phase ? haddr_in : wr_addr_q;
    rdata_d    = 32'h0000_0000;
    if (wr_pend_q) begin
      if (wr_addr_q == byte_addr(`VPF_IDX_FILTER_CONFIG)) begin
        cfg_d = hwdata_in[7:0];
      end
      // Blocked so the filter never sees a half-changed match value
      if (wr_addr_q == byte_addr(`VPF_IDX_MATCH_TYPE) && !cfg_q[`VPF_CFG_MATCH_BIT]) begin // R3
        match_d = {2'b00, hwdata_in[5:0]};
      end
    end
    // Read data fetched at the address phase so hrdata comes from a flop
    if (addr_phase && !hwrite_in) begin
      if (haddr_in == byte_addr(`VPF_IDX_FILTER_CONFIG)) begin
        rdata_d = {24'h00_0000, cfg_q};
      end else if (haddr_in == byte_addr(`VPF_IDX_MATCH_TYPE)) begin
        rdata_d = {24'h00_0000, match_q};
      end else if (haddr_in == byte_addr(`VPF_IDX_STATUS)) begin
        rdata_d = {12'h000, video_mode_75mhz_in, video_mode_100mhz_in,
                   (pkt_st_q == PS_DROP), (pkt_st_q == PS_PASS), fwd_cnt_q};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q     <= `VPF_CFG_RESET;
      match_q   <= `VPF_MATCH_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      cfg_q     <= cfg_d;
      match_q   <= match_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Packet filter: decision taken at start of packet, held to its end

  logic        pass_now;
  logic        fwd;
  logic        pv_valid_q, pv_valid_d;
  logic        pv_sop_q,   pv_sop_d;
  logic        pv_eop_q,   pv_eop_d;
  vpf_dt_t     pv_dt_q,    pv_dt_d;
  logic [DATA_W-1:0] pv_data_q, pv_data_d;
  logic        fv_q,       fv_d;
  logic        lv_q,       lv_d;

  vpf_type_filter u_filter (
    .dt_in                    (pkt_dt_in),
    .match_value_in           (match_q[5:0]),
    .pass_any_long_type_en_in (cfg_q[`VPF_CFG_ANY_BIT]),
    .type_match_en_in         (cfg_q[`VPF_CFG_MATCH_BIT]),
    .yuv10_pass_en_in         (cfg_q[`VPF_CFG_YUV_BIT]),
    .video_mode_100mhz_in     (video_mode_100mhz_in),
    .pass_out                 (pass_now)
  );

  always_comb begin
    pkt_st_d  = pkt_st_q;
    fwd       = 1'b0;
    fwd_cnt_d = fwd_cnt_q;
    if (pkt_valid_in) begin
      if (pkt_sop_in) begin
        fwd = pass_now; // R1 R2 R4
        if (pass_now) begin
          fwd_cnt_d = fwd_cnt_q + 16'h0001;
        end
        if (pkt_eop_in) begin
          pkt_st_d = PS_IDLE;
        end else begin
          pkt_st_d = pass_now ? PS_PASS : PS_DROP;
        end
      end else begin
        case (pkt_st_q)
          PS_PASS: fwd = 1'b1;
          PS_DROP: fwd = 1'b0;
          default: fwd = 1'b0;
        endcase
        if (pkt_eop_in) begin
          pkt_st_d = PS_IDLE;
        end
      end
    end
    pv_valid_d = fwd;
    pv_sop_d   = fwd && pkt_sop_in;
    pv_eop_d   = fwd && pkt_eop_in;
    pv_dt_d    = fwd ? pkt_dt_in : pv_dt_q;
    pv_data_d  = fwd ? pkt_data_in : pv_data_q;
    fv_d       = frame_valid_in ^ cfg_q[`VPF_CFG_FV_BIT]; // R7
    lv_d       = line_valid_in ^ cfg_q[`VPF_CFG_LV_BIT]; // R8
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pkt_st_q   <= PS_IDLE;
      fwd_cnt_q  <= 16'h0000;
      pv_valid_q <= 1'b0;
      pv_sop_q   <= 1'b0;
      pv_eop_q   <= 1'b0;
      pv_dt_q    <= 6'h00;
      pv_data_q  <= '0;
      fv_q       <= 1'b0;
      lv_q       <= 1'b0;
    end else begin
      pkt_st_q   <= pkt_st_d;
      fwd_cnt_q  <= fwd_cnt_d;
      pv_valid_q <= pv_valid_d;
      pv_sop_q   <= pv_sop_d;
      pv_eop_q   <= pv_eop_d;
      pv_dt_q    <= pv_dt_d;
      pv_data_q  <= pv_data_d;
      fv_q       <= fv_d;
      lv_q       <= lv_d;
    end
  end

  assign pv_valid_out    = pv_valid_q;
  assign pv_sop_out      = pv_sop_q;
  assign pv_eop_out      = pv_eop_q;
  assign pv_dt_out       = pv_dt_q;
  assign pv_data_out     = pv_data_q;
  assign frame_valid_out = fv_q;
  assign line_valid_out  = lv_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic sop_v;
  logic dt_long;
  logic dt_yuv;
  assign sop_v   = pkt_valid_in && pkt_sop_in;
  assign dt_long = pkt_dt_in[5] | pkt_dt_in[4];
  assign dt_yuv  = pkt_dt_in == `VPF_DT_YUV10_A || pkt_dt_in == `VPF_DT_YUV10_B
                   || pkt_dt_in == `VPF_DT_YUV10_C;

  property p_any_long;
    sop_v && dt_long && cfg_q[`VPF_CFG_ANY_BIT] |=> pv_valid_out && pv_sop_out
      && pv_dt_out == $past(pkt_dt_in);
  endproperty
  a_any_long: assert property (p_any_long) else $error("long packet not passed"); // R1

  property p_match;
    sop_v && cfg_q[`VPF_CFG_MATCH_BIT] && pkt_dt_in == match_q[5:0] && dt_long
      |=> pv_valid_out;
  endproperty
  a_match: assert property (p_match) else $error("matched packet not passed"); // R2

  property p_match_locked;
    wr_pend_q && wr_addr_q == byte_addr(`VPF_IDX_MATCH_TYPE) && cfg_q[`VPF_CFG_MATCH_BIT]
      |=> $stable(match_q);
  endproperty
  a_match_locked: assert property (p_match_locked) else $error("match written while locked"); // R3

  property p_yuv;
    sop_v && dt_yuv && cfg_q[`VPF_CFG_YUV_BIT] && video_mode_100mhz_in |=> pv_valid_out;
  endproperty
  a_yuv: assert property (p_yuv) else $error("yuv packet not passed"); // R4

  property p_yuv_mode_off;
    sop_v && dt_yuv && !video_mode_100mhz_in && cfg_q[`VPF_CFG_YUV_BIT]
      && !cfg_q[`VPF_CFG_ANY_BIT] && !cfg_q[`VPF_CFG_MATCH_BIT] |=> !pv_valid_out;
  endproperty
  a_yuv_mode_off: assert property (p_yuv_mode_off) else $error("yuv passed without mode"); // R4

  property p_match_any_mode;
    sop_v && !video_mode_100mhz_in && cfg_q[`VPF_CFG_MATCH_BIT] && dt_long
      && pkt_dt_in == match_q[5:0] |=> pv_valid_out;
  endproperty
  a_match_any_mode: assert property (p_match_any_mode) else $error("match needs mode"); // R5

  property p_short_dropped;
    sop_v && !dt_long |=> !pv_valid_out;
  endproperty
  a_short_dropped: assert property (p_short_dropped) else $error("short type forwarded"); // R6

  property p_fv_inv;
    ##1 frame_valid_out == ($past(frame_valid_in) ^ $past(cfg_q[`VPF_CFG_FV_BIT]));
  endproperty
  a_fv_inv: assert property (p_fv_inv) else $error("frame valid polarity wrong"); // R7

  property p_lv_inv;
    ##1 line_valid_out == ($past(line_valid_in) ^ $past(cfg_q[`VPF_CFG_LV_BIT]));
  endproperty
  a_lv_inv: assert property (p_lv_inv) else $error("line valid polarity wrong"); // R8

endmodule : vpf_top
`default_nettype wire

// *** rtl/vpf_type_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vpf_consts.svh"
module vpf_type_filter
  import vpf_pkg::*;
(
  // Packet type and settings
  input  wire vpf_dt_t dt_in,
  input  wire vpf_dt_t match_value_in,
  input  wire logic    pass_any_long_type_en_in,
  input  wire logic    type_match_en_in,
  input  wire logic    yuv10_pass_en_in,
  input  wire logic    video_mode_100mhz_in,
  // Decision
  output logic         pass_out
);

  function automatic logic is_long(input vpf_dt_t dt);
    is_long = dt[5] | dt[4];
  endfunction : is_long

  logic any_hit;
  logic match_hit;
  logic yuv_hit;

  always_comb begin
    any_hit   = pass_any_long_type_en_in && is_long(dt_in); // R1
    // Mode inputs are not consulted here on purpose
    match_hit = type_match_en_in && is_long(match_value_in) // R6
                && (dt_in == match_value_in); // R2 R5
    yuv_hit   = yuv10_pass_en_in && video_mode_100mhz_in
                && (dt_in == `VPF_DT_YUV10_A || dt_in == `VPF_DT_YUV10_B
                    || dt_in == `VPF_DT_YUV10_C); // R4
    pass_out  = any_hit || match_hit || yuv_hit;
  end

endmodule : vpf_type_filter
`default_nettype wire

// *** tb/tb_video_port_type_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_video_port_type_filter;
  import vpf_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  htrans = 2'b00;
  logic [11:0] haddr  = 12'h000;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        mode100 = 1'b0;
  logic        mode75  = 1'b0;
  logic        fv = 1'b0;
  logic        lv = 1'b0;
  wire  [31:0] hrdata;
  wire         hready, hresp, pv_valid, pv_sop, pv_eop, fvo, lvo, s_valid, s_sop, s_eop;
  wire vpf_dt_t pv_dt, s_dt;
  wire  [31:0] pv_data, s_data;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [39:0] exp_q[$];
  logic [31:0] rd;
  logic [39:0] exp_beat;

  always #25 clk_in = ~clk_in;

  vpf_top i_vpf_top (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .video_mode_100mhz_in(mode100), .video_mode_75mhz_in(mode75), .pkt_valid_in(s_valid),
    .pkt_sop_in(s_sop), .pkt_eop_in(s_eop), .pkt_dt_in(s_dt), .pkt_data_in(s_data),
    .frame_valid_in(fv), .line_valid_in(lv), .pv_valid_out(pv_valid), .pv_sop_out(pv_sop),
    .pv_eop_out(pv_eop), .pv_dt_out(pv_dt), .pv_data_out(pv_data),
    .frame_valid_out(fvo), .line_valid_out(lvo));
  vpf_pkt_src i_vpf_pkt_src (.clk_in(clk_in), .valid_out(s_valid), .sop_out(s_sop),
    .eop_out(s_eop), .dt_out(s_dt), .data_out(s_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Entered just after a rising edge; no wait count assumed, the timeout bounds it
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, 40'(rd), 40'(e));
    check("hresp", 40'(hresp), 40'h0);
  endtask : rdc

  task automatic pkt(input vpf_dt_t dt, input logic pass);
    logic [31:0] d;
    d = $urandom;
    mode75 <= 1'($urandom);
    if (pass) begin
      exp_q.push_back({2'b10, dt, d});
      // Type output follows every forwarded beat, so the scrambled eop type shows
      exp_q.push_back({2'b01, ~dt, d + 32'h1});
    end
    i_vpf_pkt_src.send(dt, d);
    repeat (2) @(posedge clk_in);
  endtask : pkt

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_in) begin
    if (pv_valid === 1'b1) begin
      exp_beat = exp_q.size() ? exp_q.pop_front() : 40'hx;
      check("pv_beat", {pv_sop, pv_eop, pv_dt, pv_data}, exp_beat);
    end
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    void'($urandom(98577));
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc("cfg_reset", 12'h040, 32'h0);
    rdc("match_reset", 12'h044, 32'h0);
    bus(1'b1, 12'h048, 32'hffffffff);
    rdc("unmapped", 12'h048, 32'h0);
    bus(1'b1, 12'h040, 32'h10);
    repeat (4) begin
      pkt(vpf_dt_t'(6'h10 + $urandom_range(47)), 1'b1);
      pkt(vpf_dt_t'($urandom_range(15)), 1'b0);
    end
    bus(1'b1, 12'h044, 32'hffffffeb);
    rdc("match_rd", 12'h044, 32'h2b);
    bus(1'b1, 12'h040, 32'h08);
    for (int m = 0; m < 2; m++) begin
      mode100 <= 1'(m);
      pkt(6'h2b, 1'b1);
      pkt(6'h2c, 1'b0);
    end
    // Write while matching is on must leave the old value
    bus(1'b1, 12'h044, 32'h15);
    rdc("match_blocked", 12'h044, 32'h2b);
    bus(1'b1, 12'h040, 32'h00);
    bus(1'b1, 12'h044, 32'h05);
    bus(1'b1, 12'h040, 32'h08);
    pkt(6'h05, 1'b0);
    bus(1'b1, 12'h040, 32'h04);
    for (int m = 0; m < 2; m++) begin
      mode100 <= 1'(m);
      for (int i = 0; i < 3; i++) begin
        pkt(i == 0 ? 6'h19 : i == 1 ? 6'h1d : 6'h1f, 1'(m));
      end
    end
    // Nine packets forwarded so far, idle between packets, 100 MHz mode left on
    rdc("status", 12'h080, {12'h000, mode75, 19'h4_0009});
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 12'h040, 32'(k));
      repeat (4) begin
        @(posedge clk_in);
        fv <= 1'($urandom);
        lv <= 1'($urandom);
        @(posedge clk_in);
        @(negedge clk_in);
        check("frame_valid", 40'(fvo), 40'(fv ^ k[1]));
        check("line_valid", 40'(lvo), 40'(lv ^ k[0]));
      end
      @(posedge clk_in);
    end
    check("left_over", 40'(exp_q.size()), 40'h0);
    close_out();
  end
endmodule : tb_video_port_type_filter
`default_nettype wire

// *** tb/vpf_pkt_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module vpf_pkt_src
  import vpf_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Packet beats towards the filter
  output var  logic        valid_out,
  output var  logic        sop_out,
  output var  logic        eop_out,
  output var  vpf_dt_t     dt_out,
  output var  logic [31:0] data_out
);
  initial begin
    {valid_out, sop_out, eop_out} = 3'b000;
    dt_out = 6'h00;
    data_out = 32'h0;
  end

  // Two-beat packet of any data type; dt is only meaningful on the sop beat, so it is scrambled after
  task automatic send(input vpf_dt_t dt, input logic [31:0] d);
    @(posedge clk_in);
    {valid_out, sop_out, eop_out} <= 3'b110;
    dt_out <= dt;
    data_out <= d;
    @(posedge clk_in);
    {valid_out, sop_out, eop_out} <= 3'b101;
    dt_out <= ~dt;
    data_out <= d + 32'h1;
    @(posedge clk_in);
    // The released data line shows the inverse so a stale value is never mistaken for data
    {valid_out, sop_out, eop_out} <= 3'b000;
    data_out <= ~(d + 32'h1);
  endtask : send
endmodule : vpf_pkt_src
`default_nettype wire
